// ===== inc/dac_seq_pkg.sv
package dac_seq_pkg;

   // ----------------------------------------
   // Device register offsets
   // ----------------------------------------
   localparam logic [6:0] DEV_SERIAL_MODE   = 7'h00;
   localparam logic [6:0] DEV_POWER_DOWN    = 7'h01;
   localparam logic [6:0] DEV_IRQ_EN_LOW    = 7'h03;
   localparam logic [6:0] DEV_IRQ_EN_HIGH   = 7'h04;
   localparam logic [6:0] DEV_IRQ_REQ_LOW   = 7'h05;
   localparam logic [6:0] DEV_IRQ_REQ_HIGH  = 7'h06;
   localparam logic [6:0] DEV_FRAME_PIN_USE = 7'h07;
   localparam logic [6:0] DEV_RESERVED      = 7'h08;
   localparam logic [6:0] DEV_DATA_CLK_CTL0 = 7'h0a;
   localparam logic [6:0] DEV_DATA_CLK_CTL1 = 7'h0b;
   localparam logic [6:0] DEV_DATA_CLK_CTL2 = 7'h0c;
   localparam logic [6:0] DEV_DATA_CLK_CTL3 = 7'h0d;
   localparam logic [6:0] DEV_FIFO_CTL      = 7'h11;
   localparam logic [6:0] DEV_FIFO_OFFSET   = 7'h12;
   localparam logic [6:0] DEV_DATA_MODE     = 7'h18;
   localparam logic [6:0] DEV_FSC_LOW       = 7'h20;
   localparam logic [6:0] DEV_FSC_HIGH      = 7'h21;
   localparam logic [6:0] DEV_CLK_CTL       = 7'h30;
   localparam logic [6:0] DEV_PLL_CTL       = 7'h33;
   localparam logic [6:0] DEV_PLL_MODE      = 7'h34;

   // ----------------------------------------
   // Device reset values
   // ----------------------------------------
   localparam logic [7:0] RST_SERIAL_MODE   = 8'h81;
   localparam logic [7:0] RST_POWER_DOWN    = 8'h48;
   localparam logic [7:0] RST_RESERVED      = 8'h58;
   localparam logic [7:0] RST_DATA_CLK_CTL0 = 8'h40;

   // ----------------------------------------
   // Start-up values
   // ----------------------------------------
   localparam logic [7:0] VAL_MODE          = 8'h00;
   localparam logic [7:0] VAL_CLK_FIRST     = 8'h5c;
   localparam logic [7:0] VAL_DLL_MIN       = 8'h64;
   localparam logic [7:0] VAL_DLL_DIV       = 8'h39;
   localparam logic [7:0] VAL_BIAS_DOWN     = 8'h68;
   localparam logic [7:0] VAL_PLL_MODE_S    = 8'h6d;
   localparam logic [7:0] VAL_PLL_MODE_L    = 8'h5d;
   localparam logic [7:0] VAL_BIAS_UP       = 8'h48;
   localparam logic [7:0] VAL_PLL_INIT      = 8'h13;
   localparam logic [7:0] VAL_PLL_PFD_S     = 8'hf8;
   localparam logic [7:0] VAL_PLL_PFD_L     = 8'hd8;
   localparam logic [7:0] VAL_PLL_RUN_S     = 8'hf0;
   localparam logic [7:0] VAL_PLL_RUN_L     = 8'hd0;
   localparam logic [7:0] VAL_DUTY_BW       = 8'h06;
   localparam logic [7:0] VAL_DLL_ON        = 8'hc0;
   localparam logic [7:0] VAL_FSC_LOW       = 8'hc6;
   localparam logic [7:0] VAL_FSC_HIGH      = 8'h03;
   localparam logic [7:0] VAL_CLK_FINAL     = 8'h46;
   localparam logic [7:0] VAL_FIFO_PTR      = 8'h20;
   localparam logic [7:0] VAL_FIFO_RST_ON   = 8'h81;
   localparam logic [7:0] VAL_FIFO_RST_OFF  = 8'h01;
   localparam logic [7:0] VAL_REF_ON        = 8'h08;
   localparam logic [3:0] DATA_MODE_DEF     = 4'h4;

   localparam int         STEP_COUNT        = 20;
   localparam logic [4:0] STEP_LAST         = 5'd19;

   // ----------------------------------------
   // Controller APB register map
   // ----------------------------------------
   localparam logic [11:0] APB_CTRL   = 12'h000;
   localparam logic [11:0] APB_STATUS = 12'h004;
   localparam logic [11:0] APB_ACCESS = 12'h008;
   localparam logic [11:0] APB_RDATA  = 12'h00c;

   // CTRL fields
   localparam int CTRL_START   = 0;
   localparam int CTRL_LONG    = 1;
   localparam int CTRL_MODE_LO = 4;
   localparam int CTRL_MODE_HI = 7;
   // ACCESS fields
   localparam int ACC_DATA_LO  = 0;
   localparam int ACC_DATA_HI  = 7;
   localparam int ACC_ADDR_LO  = 8;
   localparam int ACC_ADDR_HI  = 14;
   localparam int ACC_READ     = 15;

   // Serial framing
   localparam logic [4:0] SPI_BITS     = 5'd16;
   localparam logic [3:0] SCLK_HALF    = 4'd4;

endpackage

// ===== rtl/dac_seq_host.sv
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module dac_seq_host
   import dac_seq_pkg::*;
(
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_reset,
   // APB slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // Device serial port
   output logic             o_spi_csb_n,
   output logic             o_spi_sclk,
   output logic             o_spi_sdi,
   input  wire logic        i_spi_sdo
);

   // ----------------------------------------
   // Types and state
   // ----------------------------------------
   typedef enum {ST_IDLE, ST_LOAD, ST_SHIFT, ST_NEXT} state_type;

   state_type   state_reg;
   logic [4:0]  step_reg;
   logic        run_seq_reg;
   logic        busy_reg;
   logic        done_reg;
   logic        long_reg;
   logic [3:0]  mode_reg;
   logic [15:0] acc_reg;
   logic        acc_pend_reg;
   logic [15:0] shift_reg;
   logic [7:0]  rdata_reg;
   logic [4:0]  bit_reg;
   logic [3:0]  div_reg;
   logic        sclk_reg;
   logic        csb_n_reg;
   logic        sdi_reg;
   logic [2:0]  sdo_sync_reg;
   logic        sdo_hold_reg;
   logic [31:0] prdata_reg;

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   wire apb_acc    = i_psel & i_penable;
   wire apb_wr     = apb_acc & i_pwrite;
   wire hit_ctrl   = (i_paddr == APB_CTRL);
   wire hit_status = (i_paddr == APB_STATUS);
   wire hit_access = (i_paddr == APB_ACCESS);
   wire hit_rdata  = (i_paddr == APB_RDATA);
   wire hit_any    = hit_ctrl | hit_status | hit_access | hit_rdata;
   wire start_wr   = apb_wr & hit_ctrl & i_pwdata[CTRL_START] & ~busy_reg;
   wire access_wr  = apb_wr & hit_access & ~busy_reg;
   wire capture_rd = i_psel & ~i_penable;

   assign o_pready  = 1'b1;
   assign o_pslverr = apb_acc & ~hit_any;
   assign o_prdata  = prdata_reg;

   wire [31:0] ctrl_word = {24'h000000, mode_reg, 2'b00, long_reg, 1'b0};
   wire [31:0] stat_word = {19'h00000, step_reg, 6'h00, done_reg, busy_reg};
   wire [31:0] rd_mux = hit_ctrl   ? ctrl_word :
                        hit_status ? stat_word :
                        hit_access ? {16'h0000, acc_reg} :
                        hit_rdata  ? {24'h000000, rdata_reg} : 32'h00000000;

   // ----------------------------------------
   // Start-up step table
   // ----------------------------------------
   logic [6:0] step_addr;
   logic [7:0] step_data;

   always_comb begin
      step_addr = DEV_SERIAL_MODE;
      step_data = VAL_MODE;
      case (step_reg)
         5'd0: begin
            step_addr = DEV_SERIAL_MODE;
            step_data = VAL_MODE;
         end
         5'd1: begin
            step_addr = DEV_CLK_CTL;
            step_data = VAL_CLK_FIRST;
         end
         5'd2: begin
            step_addr = DEV_DATA_CLK_CTL2;
            step_data = VAL_DLL_MIN;
         end
         5'd3: begin
            step_addr = DEV_DATA_CLK_CTL1;
            step_data = VAL_DLL_DIV;
         end
         5'd4: begin
            step_addr = DEV_POWER_DOWN;
            step_data = VAL_BIAS_DOWN;
         end
         5'd5: begin
            step_addr = DEV_PLL_MODE;
            step_data = long_reg ? VAL_PLL_MODE_L : VAL_PLL_MODE_S;
         end
         5'd6: begin
            step_addr = DEV_POWER_DOWN;
            step_data = VAL_BIAS_UP;
         end
         5'd7: begin
            step_addr = DEV_PLL_CTL;
            step_data = VAL_PLL_INIT;
         end
         5'd8: begin
            step_addr = DEV_PLL_CTL;
            step_data = long_reg ? VAL_PLL_PFD_L : VAL_PLL_PFD_S;
         end
         5'd9: begin
            step_addr = DEV_PLL_CTL;
            step_data = long_reg ? VAL_PLL_RUN_L : VAL_PLL_RUN_S;
         end
         5'd10: begin
            step_addr = DEV_DATA_CLK_CTL3;
            step_data = VAL_DUTY_BW;
         end
         5'd11: begin
            step_addr = DEV_DATA_CLK_CTL0;
            step_data = VAL_DLL_ON;
         end
         5'd12: begin
            step_addr = DEV_DATA_MODE;
            step_data = {mode_reg, 4'h0};
         end
         5'd13: begin
            step_addr = DEV_FSC_LOW;
            step_data = VAL_FSC_LOW;
         end
         5'd14: begin
            step_addr = DEV_FSC_HIGH;
            step_data = VAL_FSC_HIGH;
         end
         5'd15: begin
            step_addr = DEV_CLK_CTL;
            step_data = VAL_CLK_FINAL;
         end
         5'd16: begin
            step_addr = DEV_FIFO_OFFSET;
            step_data = VAL_FIFO_PTR;
         end
         5'd17: begin
            step_addr = DEV_FIFO_CTL;
            step_data = VAL_FIFO_RST_ON;
         end
         5'd18: begin
            step_addr = DEV_FIFO_CTL;
            step_data = VAL_FIFO_RST_OFF;
         end
         5'd19: begin
            step_addr = DEV_POWER_DOWN;
            step_data = VAL_REF_ON;
         end
         default: begin
            step_addr = DEV_SERIAL_MODE;
            step_data = VAL_MODE;
         end
      endcase
   end

   // Serial frame: r/w bit, 7-bit address, 8-bit data, MSB first
   wire [15:0] frame_seq = {1'b0, step_addr, step_data};
   wire [15:0] frame_acc = acc_reg;
   wire        last_bit  = (bit_reg == SPI_BITS - 5'd1);
   wire        half_tick = (div_reg == SCLK_HALF - 4'd1);
   wire        rise_now  = half_tick & ~sclk_reg;
   wire        fall_now  = half_tick & sclk_reg;
   wire        sdo_agree = (sdo_sync_reg[1] == sdo_sync_reg[2]);
   wire        sdo_level = sdo_agree ? sdo_sync_reg[2] : sdo_hold_reg;
   wire        seq_last  = (step_reg == STEP_LAST);

   // ----------------------------------------
   // Serial engine next values
   // ----------------------------------------
   wire        in_load    = (state_reg == ST_LOAD);
   wire        in_shift   = (state_reg == ST_SHIFT);
   wire        shift_adv  = in_shift & fall_now & ~last_bit;
   wire        frame_end  = in_shift & fall_now & last_bit;
   wire        clk_rise   = in_shift & rise_now;
   wire        clk_fall   = in_shift & fall_now;
   wire [15:0] frame_new  = acc_pend_reg ? frame_acc : frame_seq;
   wire [3:0]  div_next   = (in_shift & ~half_tick) ? div_reg + 4'd1 : 4'd0;
   wire [4:0]  bit_next   = in_load   ? 5'd0 :
                            shift_adv ? bit_reg + 5'd1 : bit_reg;
   wire [15:0] shift_next = in_load   ? frame_new :
                            shift_adv ? {shift_reg[14:0], 1'b0} : shift_reg;
   wire        sdi_next   = in_load   ? frame_new[15] :
                            shift_adv ? shift_reg[14] : sdi_reg;
   wire        sclk_next  = in_load  ? 1'b0 :
                            clk_rise ? 1'b1 :
                            clk_fall ? 1'b0 : sclk_reg;
   wire        csb_n_next = in_load   ? 1'b0 :
                            frame_end ? 1'b1 : csb_n_reg;
   wire [7:0]  rdata_next = clk_rise ? {rdata_reg[6:0], sdo_level} :
                            rdata_reg;

   // ----------------------------------------
   // APB registers
   // ----------------------------------------
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         long_reg   <= 1'b0;
         mode_reg   <= DATA_MODE_DEF;
         acc_reg    <= 16'h0000;
      end else begin
         if (apb_wr & hit_ctrl & ~busy_reg) begin
            long_reg <= i_pwdata[CTRL_LONG];
            mode_reg <= i_pwdata[CTRL_MODE_HI:CTRL_MODE_LO];
         end
         if (access_wr) begin
            acc_reg <= i_pwdata[ACC_READ:ACC_DATA_LO];
         end
      end
   end

   // Read data, captured in the setup cycle
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         prdata_reg <= 32'h00000000;
      end else if (capture_rd) begin
         prdata_reg <= rd_mux;
      end
   end

   // Input synchroniser for serial data out
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         sdo_sync_reg <= 3'b000;
      end else begin
         sdo_sync_reg <= {sdo_sync_reg[1:0], i_spi_sdo};
      end
   end

   // Level follows only when the last two stages agree
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         sdo_hold_reg <= 1'b0;
      end else begin
         sdo_hold_reg <= sdo_level;
      end
   end

   // ----------------------------------------
   // Sequencer and serial engine
   // ----------------------------------------
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         state_reg    <= ST_IDLE;
         step_reg     <= 5'd0;
         run_seq_reg  <= 1'b0;
         busy_reg     <= 1'b0;
         done_reg     <= 1'b0;
         acc_pend_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (start_wr) begin
                  step_reg    <= 5'd0;
                  run_seq_reg <= 1'b1;
                  busy_reg    <= 1'b1;
                  done_reg    <= 1'b0;
                  state_reg   <= ST_LOAD;
               end else if (access_wr) begin
                  run_seq_reg  <= 1'b0;
                  busy_reg     <= 1'b1;
                  acc_pend_reg <= 1'b1;
                  state_reg    <= ST_LOAD;
               end
            end
            ST_LOAD: begin
               state_reg <= ST_SHIFT;
            end
            ST_SHIFT: begin
               if (frame_end) begin
                  state_reg <= ST_NEXT;
               end
            end
            ST_NEXT: begin
               acc_pend_reg <= 1'b0;
               if (run_seq_reg & ~seq_last) begin
                  step_reg  <= step_reg + 5'd1;
                  state_reg <= ST_LOAD;
               end else begin
                  done_reg    <= run_seq_reg | done_reg;
                  run_seq_reg <= 1'b0;
                  busy_reg    <= 1'b0;
                  state_reg   <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Pin outputs
   // ----------------------------------------
   assign o_spi_csb_n = csb_n_reg;
   assign o_spi_sclk  = sclk_reg;
   assign o_spi_sdi   = sdi_reg;

   // ----------------------------------------
   // Serial registers
   // ----------------------------------------
   // Shifter, bit count and data pin
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         shift_reg <= 16'h0000;
         bit_reg   <= 5'd0;
         sdi_reg   <= 1'b0;
      end else begin
         shift_reg <= shift_next;
         bit_reg   <= bit_next;
         sdi_reg   <= sdi_next;
      end
   end

   // Clock divider, clock and select pins
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         div_reg   <= 4'd0;
         sclk_reg  <= 1'b0;
         csb_n_reg <= 1'b1;
      end else begin
         div_reg   <= div_next;
         sclk_reg  <= sclk_next;
         csb_n_reg <= csb_n_next;
      end
   end

   // Read-back capture at each clock rise
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

endmodule

// ===== testbench/dac_seq_host_asserts.sv
`timescale 1ns/1ps
module dac_seq_host_asserts (
   input wire logic        i_core_clk,
   input wire logic        i_reset,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   input wire logic        o_spi_csb_n,
   input wire logic        o_spi_sclk,
   input wire logic        o_spi_sdi,
   input wire logic        i_spi_sdo
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   logic [4:0] rise_cnt;
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset)
         rise_cnt <= 5'h00;
      else if ($fell(o_spi_csb_n))
         rise_cnt <= 5'h00;
      else if ($rose(o_spi_sclk))
         rise_cnt <= rise_cnt + 5'h01;
   end
   chk_read_hold: assert property (i_psel && i_penable |->
      o_pready ##1 $stable(o_prdata))
      else $error("read data not held after access");
   chk_slverr_map: assert property (i_psel && i_penable |->
      (o_pslverr == (i_paddr > 12'h00c || i_paddr[1:0] != 2'h0)))
      else $error("slave error does not follow map");
   chk_sclk_idle: assert property (o_spi_csb_n |-> !o_spi_sclk)
      else $error("clock active outside frame");
   chk_sdi_stable: assert property (o_spi_sclk && $past(o_spi_sclk) |->
      $stable(o_spi_sdi))
      else $error("data moved while clock high");
   chk_sclk_high: assert property ($rose(o_spi_sclk) |->
      o_spi_sclk [*4] ##1 !o_spi_sclk)
      else $error("clock high phase wrong");
   chk_sclk_low: assert property ($fell(o_spi_sclk) |->
      !o_spi_sclk [*4])
      else $error("clock low phase short");
   chk_frame_lead: assert property ($fell(o_spi_csb_n) |->
      !o_spi_sclk [*4] ##1 o_spi_sclk)
      else $error("first clock rise misplaced");
   chk_frame_gap: assert property ($rose(o_spi_csb_n) |->
      o_spi_csb_n [*2])
      else $error("select gap too short");
   chk_frame_len: assert property ($rose(o_spi_csb_n) |->
      rise_cnt == 5'h10)
      else $error("frame not sixteen bits");
   cover property ($rose(o_spi_csb_n));
   cover property (o_pslverr);
   cover property (i_psel && i_penable && i_pwrite && i_paddr == 12'h000);
endmodule
bind dac_seq_host dac_seq_host_asserts chk (.i_core_clk, .i_reset, .i_psel,
   .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
   .o_pslverr, .o_spi_csb_n, .o_spi_sclk, .o_spi_sdi, .i_spi_sdo);

// ===== testbench/dac_dev_model.sv
`timescale 1ns/1ps
module dac_dev_model (
   input  wire logic i_spi_csb_n,
   input  wire logic i_spi_sclk,
   input  wire logic i_spi_sdi,
   output logic      o_spi_sdo,
   output logic      o_irq
);
   logic [7:0]  regs [0:127];
   logic [6:0]  log_a [0:63];
   logic [7:0]  log_d [0:63];
   int          n_log;
   int          cnt;
   logic [14:0] sh;
   logic [6:0]  addr_lat;
   logic        rd_lat;
   wire  [9:0]  fsc_code = {regs[33][1:0], regs[32]};
   initial begin
      for (int k = 0; k < 128; k++) regs[k] = 8'h00;
      regs[0] = 8'h81;
      regs[1] = 8'h48;
      regs[8] = 8'h58;
      regs[10] = 8'h40;
      regs[33] = 8'h02;
      n_log = 0;
      cnt = 0;
      rd_lat = 1'b0;
      o_spi_sdo = 1'b0;
   end
   assign o_irq = |((regs[3] & regs[5]) | (regs[4] & regs[6]));
   // ----------------------------------------
   // Serial slave
   // ----------------------------------------
   always @(posedge i_spi_sclk) begin
      if (!i_spi_csb_n) begin
         if (cnt == 7) begin
            addr_lat = {sh[5:0], i_spi_sdi};
            rd_lat = sh[6];
         end
         if (cnt == 15 && !rd_lat) begin
            log_a[n_log] = addr_lat;
            log_d[n_log] = {sh[6:0], i_spi_sdi};
            n_log++;
            if (addr_lat == 7'h00)
               regs[0] = {sh[6:4], 2'b00, sh[4], sh[5], sh[6]};
            else if (addr_lat != 7'h08)
               regs[addr_lat] = {sh[6:0], i_spi_sdi};
         end
         sh = {sh[13:0], i_spi_sdi};
         cnt++;
      end
   end
   always @(negedge i_spi_sclk) begin
      if (!i_spi_csb_n && rd_lat && cnt >= 8 && cnt < 16)
         o_spi_sdo <= regs[addr_lat][15 - cnt];
   end
   always @(posedge i_spi_csb_n) begin
      cnt = 0;
      o_spi_sdo <= ~o_spi_sdo;
   end
endmodule

// ===== testbench/test_dac_seq_host.sv
`timescale 1ns/1ps
module test_dac_seq_host;
   import dac_seq_pkg::*;
   logic        i_core_clk;
   logic        i_reset;
   logic        i_psel;
   logic        i_penable;
   logic        i_pwrite;
   logic [11:0] i_paddr;
   logic [31:0] i_pwdata;
   logic [31:0] o_prdata;
   logic        o_pready;
   logic        o_pslverr;
   logic        o_spi_csb_n;
   logic        o_spi_sclk;
   logic        o_spi_sdi;
   logic        i_spi_sdo;
   int          n_fail;
   int          checked;
   int          base;
   logic [31:0] rd;
   logic        err;
   dac_seq_host DUT (.i_core_clk, .i_reset, .i_psel, .i_penable, .i_pwrite,
      .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_spi_csb_n,
      .o_spi_sclk, .o_spi_sdi, .i_spi_sdo);
   dac_dev_model dev (.i_spi_csb_n(o_spi_csb_n), .i_spi_sclk(o_spi_sclk),
      .i_spi_sdi(o_spi_sdi), .o_spi_sdo(i_spi_sdo), .o_irq());
   initial begin
      i_core_clk = 1'b0;
      forever #2.5 i_core_clk = ~i_core_clk;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task conclude;
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_core_clk);
      i_penable <= 1'b1;
      do @(posedge i_core_clk); while (o_pready !== 1'b1);
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   task wait_bit(input int b, input logic v);
      do apb(1'b0, APB_STATUS, 32'h0); while (rd[b] !== v);
   endtask
   task dev_rd(input logic [6:0] a);
      apb(1'b1, APB_ACCESS, {16'h0, 1'b1, a, 8'h00});
      wait_bit(0, 1'b0);
      apb(1'b0, APB_RDATA, 32'h0);
   endtask
   function automatic logic [14:0] exp_frame(int i, logic l, logic [3:0] m);
      case (i)
         0: return {7'h00, 8'h00};
         1: return {7'h30, 8'h5c};
         2: return {7'h0c, 8'h64};
         3: return {7'h0b, 8'h39};
         4: return {7'h01, 8'h68};
         5: return {7'h34, l ? 8'h5d : 8'h6d};
         6: return {7'h01, 8'h48};
         7: return {7'h33, 8'h13};
         8: return {7'h33, l ? 8'hd8 : 8'hf8};
         9: return {7'h33, l ? 8'hd0 : 8'hf0};
         10: return {7'h0d, 8'h06};
         11: return {7'h0a, 8'hc0};
         12: return {7'h18, m, 4'h0};
         13: return {7'h20, 8'hc6};
         14: return {7'h21, 8'h03};
         15: return {7'h30, 8'h46};
         16: return {7'h12, 8'h20};
         17: return {7'h11, 8'h81};
         18: return {7'h11, 8'h01};
         default: return {7'h01, 8'h08};
      endcase
   endfunction
   task run_seq(input logic l, input logic [3:0] m);
      base = dev.n_log;
      apb(1'b1, APB_CTRL, {24'h0, m, 2'b00, l, 1'b1});
      apb(1'b1, APB_CTRL, {24'h0, ~m, 2'b00, ~l, 1'b1});
      wait_bit(1, 1'b1);
      check({30'h0, rd[1:0]}, 32'h2);
      check({27'h0, rd[12:8]}, 32'd19);
      apb(1'b0, APB_CTRL, 32'h0);
      check(rd, {24'h0, m, 2'b00, l, 1'b0});
      check(32'(dev.n_log - base), 32'd20);
      for (int i = 0; i < 20; i++)
         check({17'h0, dev.log_a[base + i], dev.log_d[base + i]},
               {17'h0, exp_frame(i, l, m)});
      check({24'h0, dev.regs[1]}, 32'h08);
      check({22'h0, dev.fsc_code}, 32'h3c6);
      $display("startup test done");
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      i_reset = 1'b1;
      i_psel = 1'b0;
      i_penable = 1'b0;
      i_pwrite = 1'b0;
      i_paddr = 12'h000;
      i_pwdata = 32'h0;
      n_fail = 0;
      checked = 0;
      repeat (12) @(posedge i_core_clk);
      i_reset <= 1'b0;
      apb(1'b0, APB_CTRL, 32'h0);
      check(rd, 32'h40);
      apb(1'b0, APB_STATUS, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      apb(1'b1, 12'h020, 32'hff);
      check({31'h0, err}, 32'h1);
      apb(1'b1, APB_CTRL, 32'h52);
      apb(1'b0, APB_CTRL, 32'h0);
      check(rd, 32'h52);
      check({31'h0, err}, 32'h0);
      check(32'(dev.n_log), 32'd0);
      dev_rd(7'h00);
      check(rd, 32'h81);
      dev_rd(7'h01);
      check(rd, 32'h48);
      dev_rd(7'h08);
      check(rd, 32'h58);
      dev_rd(7'h0a);
      check(rd, 32'h40);
      $display("reset test done");
      run_seq(1'b0, 4'h4);
      run_seq(1'b1, 4'ha);
      apb(1'b1, APB_ACCESS, {16'h0, 1'b0, 7'h03, 8'h5a});
      wait_bit(0, 1'b0);
      dev_rd(7'h03);
      check(rd, 32'h5a);
      check({31'h0, dev.o_irq}, 32'h0);
      $display("access test done");
      conclude();
   end
   initial begin
      #400000;
      n_fail++;
      conclude();
   end
endmodule
